// file: acs_pkg.sv
// acs_pkg: register map, field layout and defaults of the audio clock synthesis configuration bank
// assumes a 16-bit word register file reached over classic wishbone, word index times four
package acs_pkg;
   localparam logic [7:0] ACS_IDX_NUM_LO = 8'h33;
   localparam logic [7:0] ACS_IDX_NUM_HI = 8'h34;
   localparam logic [7:0] ACS_IDX_DEN_LO = 8'h35;
   localparam logic [7:0] ACS_IDX_DEN_HI = 8'h36;
   localparam logic [7:0] ACS_IDX_RSV_A = 8'h37;
   localparam logic [7:0] ACS_IDX_RSV_B = 8'h38;
   localparam logic [7:0] ACS_IDX_CAP = 8'h39;
   localparam logic [7:0] ACS_IDX_RES = 8'h3a;
   localparam logic [7:0] ACS_IDX_FB_LO = 8'h3b;
   localparam logic [7:0] ACS_IDX_FB_HI = 8'h3c;
   localparam logic [7:0] ACS_IDX_REF_LO = 8'h3d;
   localparam logic [7:0] ACS_IDX_REF_HI = 8'h3e;
   localparam logic [7:0] ACS_IDX_RATE = 8'h3f;
   localparam logic [7:0] ACS_IDX_UPD = 8'h30;
   localparam int ACS_LOOP_W = 6;
   localparam int ACS_RATE_W = 3;
   localparam int ACS_UPD_BIT = 0;
   localparam logic [2:0] ACS_RATE_RST = 3'h0;
   localparam logic [2:0] ACS_RATE_384 = 3'h1;
   localparam logic [2:0] ACS_RATE_192 = 3'h3;
   localparam logic [5:0] ACS_CAP_MIN = 6'h0a;
   localparam logic [5:0] ACS_CAP_MARGIN = 6'h15;
   localparam logic [5:0] ACS_RES_MIN = 6'h20;
   localparam logic [5:0] ACS_RES_MAX = 6'h2a;
   localparam logic [15:0] ACS_DEF_NUM_LO = 16'h0001;
   localparam logic [15:0] ACS_DEF_DEN_LO = 16'h0001;
   localparam logic [15:0] ACS_DEF_FB_LO = 16'h0001;
   localparam logic [15:0] ACS_DEF_REF_LO = 16'h0001;
   localparam logic [5:0] ACS_DEF_CAP = 6'h0c;
   localparam logic [5:0] ACS_DEF_RES = 6'h22;
   typedef enum logic [2:0] {
      ACS_IDLE = 3'b001,
      ACS_ACK = 3'b010,
      ACS_HOLD = 3'b100
   } acs_bus_st_t;
endpackage

// file: acs_word_reg.sv
// acs_word_reg: one configuration word of W bits, 16 by default, with byte-lane write and a load-default strobe
// assumes write strobe and lanes come from the bus slave on the same clock
`timescale 1ns/10ps
module acs_word_reg
   import acs_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] rst_val_i,
   input wire logic load_def_i,
   input wire logic wr_i,
   input wire logic [1:0] sel_i,
   input wire logic [15:0] wdat_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] q_reg;
   logic [15:0] wide_q;
   logic [15:0] merged;
   logic [W-1:0] q_next;

   assign wide_q = 16'(q_reg);
   assign merged = {sel_i[1] ? wdat_i[15:8] : wide_q[15:8], sel_i[0] ? wdat_i[7:0] : wide_q[7:0]};
   assign q_next = load_def_i ? rst_val_i : (wr_i ? merged[W-1:0] : q_reg);

   // the default is a port, so it is loaded by the clock like any write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end
   assign q_o = q_reg;
endmodule // acs_word_reg

// file: acs_ratio_stage.sv
// acs_ratio_stage: holds a 32-bit ratio parameter in use and takes the programmed one on update when it is non-zero
// assumes the update strobe is a one-cycle pulse on the same clock
`timescale 1ns/10ps
module acs_ratio_stage
   import acs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] prog_i,
   input wire logic [31:0] rst_val_i,
   input wire logic load_def_i,
   input wire logic upd_i,
   output logic [31:0] act_o
);
   logic [31:0] act_reg;
   logic [31:0] act_next;
   logic take;

   // a zero parameter keeps the value already in use
   assign take = upd_i && (prog_i != 32'h0);
   assign act_next = load_def_i ? rst_val_i : (take ? prog_i : act_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_reg <= 32'h0;
      end else begin
         act_reg <= act_next;
      end
   end
   assign act_o = act_reg;
endmodule // acs_ratio_stage

// file: acs_regs.sv
// acs_regs: audio clock synthesis configuration bank on a classic wishbone slave
// assumes defaults arrive from the rate and video standard selection logic as plain inputs
// How it works
// - a 32-bit audio ratio numerator is held and drives the synthesizer.
// - numerator low half sits at word 33h, high half at 34h.
// - 32-bit denominator with low half at 35h and high half at 36h.
// - ratio defaults follow the selected audio sample rate.
// - loop bandwidth defaults follow the selected fundamental sampling frequency.
// - feedback divide value, low half at 3Bh, high half at 3Ch.
// - reference divide value, low half at 3Dh, high half at 3Eh.
// - written divide values drive the audio genlock for manual lock.
// - divide defaults follow the selected output video standard.
// - 3-bit first audio clock rate select, reset to zero.
// - a rising update bit puts non-zero ratio values into use.
`timescale 1ns/10ps
module acs_regs
   import acs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic rate_def_stb_i,
   input wire logic [31:0] def_num_i,
   input wire logic [31:0] def_den_i,
   input wire logic fs_def_stb_i,
   input wire logic [5:0] def_cap_i,
   input wire logic [5:0] def_res_i,
   input wire logic std_def_stb_i,
   input wire logic [31:0] def_fb_i,
   input wire logic [31:0] def_ref_i,
   input wire logic mid_multiple_rate_enable_i,
   output logic [31:0] audio_ratio_numerator_o,
   output logic [31:0] audio_ratio_denominator_o,
   output logic [5:0] loop_cap_o,
   output logic [5:0] loop_res_o,
   output logic [31:0] lock_feedback_div_o,
   output logic [31:0] lock_reference_div_o,
   output logic [2:0] audio_clock_out_first_rate_o,
   output logic loop_range_ok_o,
   output logic rate_sel_ok_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // bus slave
   acs_bus_st_t st_reg;
   acs_bus_st_t st_next;
   logic [7:0] idx;
   logic req;
   logic hit;
   logic wr_go;
   logic [1:0] lane;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic err_reg;

   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i;
   assign lane = wb_sel_i[1:0];
   // reserved words are mapped but inert, so they answer with ack and read zero
   assign hit = (idx >= ACS_IDX_NUM_LO && idx <= ACS_IDX_RATE) || idx == ACS_IDX_UPD;
   assign wr_go = (st_reg == ACS_IDLE) && req && wb_we_i && hit;

   always_comb begin
      case (st_reg)
         ACS_IDLE: st_next = req ? ACS_ACK : ACS_IDLE;
         ACS_ACK: st_next = ACS_HOLD;
         ACS_HOLD: st_next = req ? ACS_HOLD : ACS_IDLE;
         default: st_next = ACS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ACS_IDLE;
         rdat_reg <= 32'h0;
         err_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         rdat_reg <= rdat_next;
         err_reg <= (st_reg == ACS_IDLE) && req && !hit;
      end
   end
   // one-cycle answer the edge after the request is seen; a held request waits for release
   assign wb_ack_o = (st_reg == ACS_ACK) && !err_reg;
   assign wb_err_o = (st_reg == ACS_ACK) && err_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // word strobes
   logic wr_num_lo;
   logic wr_num_hi;
   logic wr_den_lo;
   logic wr_den_hi;
   logic wr_cap;
   logic wr_res;
   logic wr_fb_lo;
   logic wr_fb_hi;
   logic wr_ref_lo;
   logic wr_ref_hi;
   logic wr_rate;
   logic wr_upd;
   assign wr_num_lo = wr_go && idx == ACS_IDX_NUM_LO;
   assign wr_num_hi = wr_go && idx == ACS_IDX_NUM_HI;
   assign wr_den_lo = wr_go && idx == ACS_IDX_DEN_LO;
   assign wr_den_hi = wr_go && idx == ACS_IDX_DEN_HI;
   assign wr_cap = wr_go && idx == ACS_IDX_CAP;
   assign wr_res = wr_go && idx == ACS_IDX_RES;
   assign wr_fb_lo = wr_go && idx == ACS_IDX_FB_LO;
   assign wr_fb_hi = wr_go && idx == ACS_IDX_FB_HI;
   assign wr_ref_lo = wr_go && idx == ACS_IDX_REF_LO;
   assign wr_ref_hi = wr_go && idx == ACS_IDX_REF_HI;
   assign wr_rate = wr_go && idx == ACS_IDX_RATE;
   assign wr_upd = wr_go && idx == ACS_IDX_UPD;

   ////////////////////////////////////////////////////////////////////////////////
   // programmed words
   logic [15:0] num_lo;
   logic [15:0] num_hi;
   logic [15:0] den_lo;
   logic [15:0] den_hi;
   logic [15:0] fb_lo;
   logic [15:0] fb_hi;
   logic [15:0] ref_lo;
   logic [15:0] ref_hi;
   logic [5:0] cap_q;
   logic [5:0] res_q;
   logic [2:0] rate_q;
   logic [0:0] upd_q;

   // ratio words reload on a sample rate change
   acs_word_reg u_num_lo (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_num_i[15:0]),
      .load_def_i(rate_def_stb_i), .wr_i(wr_num_lo), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(num_lo));
   acs_word_reg u_num_hi (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_num_i[31:16]),
      .load_def_i(rate_def_stb_i), .wr_i(wr_num_hi), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(num_hi));
   acs_word_reg u_den_lo (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_den_i[15:0]),
      .load_def_i(rate_def_stb_i), .wr_i(wr_den_lo), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(den_lo));
   acs_word_reg u_den_hi (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_den_i[31:16]),
      .load_def_i(rate_def_stb_i), .wr_i(wr_den_hi), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(den_hi));
   // loop controls hold only the low six bits; upper bits are expected zero
   acs_word_reg #(.W(ACS_LOOP_W)) u_cap (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_cap_i),
      .load_def_i(fs_def_stb_i), .wr_i(wr_cap), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(cap_q));
   acs_word_reg #(.W(ACS_LOOP_W)) u_res (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_res_i),
      .load_def_i(fs_def_stb_i), .wr_i(wr_res), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(res_q));
   // divide words reload on a video standard change
   acs_word_reg u_fb_lo (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_fb_i[15:0]),
      .load_def_i(std_def_stb_i), .wr_i(wr_fb_lo), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(fb_lo));
   acs_word_reg u_fb_hi (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_fb_i[31:16]),
      .load_def_i(std_def_stb_i), .wr_i(wr_fb_hi), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(fb_hi));
   acs_word_reg u_ref_lo (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_ref_i[15:0]),
      .load_def_i(std_def_stb_i), .wr_i(wr_ref_lo), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(ref_lo));
   acs_word_reg u_ref_hi (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(def_ref_i[31:16]),
      .load_def_i(std_def_stb_i), .wr_i(wr_ref_hi), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(ref_hi));
   // rate select has a fixed zero reset and no other default
   acs_word_reg #(.W(ACS_RATE_W)) u_rate (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(ACS_RATE_RST),
      .load_def_i(1'b0), .wr_i(wr_rate), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(rate_q));
   acs_word_reg #(.W(1)) u_upd (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0),
      .load_def_i(1'b0), .wr_i(wr_upd), .sel_i(lane), .wdat_i(wb_dat_i[15:0]),
      .q_o(upd_q));

   ////////////////////////////////////////////////////////////////////////////////
   // update edge and ratio in use
   logic upd_d_reg;
   logic upd_rise;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd_d_reg <= 1'b0;
      end else begin
         upd_d_reg <= upd_q[0];
      end
   end
   // only a low to high change of the bit moves values; holding it high does nothing
   assign upd_rise = upd_q[0] && !upd_d_reg;

   acs_ratio_stage u_num_use (.clk_i(clk_i), .rst_i(rst_i), .prog_i({num_hi, num_lo}),
      .rst_val_i(def_num_i), .load_def_i(rate_def_stb_i), .upd_i(upd_rise),
      .act_o(audio_ratio_numerator_o));
   acs_ratio_stage u_den_use (.clk_i(clk_i), .rst_i(rst_i), .prog_i({den_hi, den_lo}),
      .rst_val_i(def_den_i), .load_def_i(rate_def_stb_i), .upd_i(upd_rise),
      .act_o(audio_ratio_denominator_o));

   ////////////////////////////////////////////////////////////////////////////////
   // outputs to the genlock and clock generators
   assign loop_cap_o = cap_q;
   assign loop_res_o = res_q;
   // divide values feed the genlock directly, no update strobe needed
   assign lock_feedback_div_o = {fb_hi, fb_lo};
   assign lock_reference_div_o = {ref_hi, ref_lo};
   assign audio_clock_out_first_rate_o = rate_q;
   // status only: a misprogrammed loop is flagged, not corrected
   assign loop_range_ok_o = (res_q >= ACS_RES_MIN) && (res_q <= ACS_RES_MAX)
      && (cap_q >= ACS_CAP_MIN) && ({1'b0, cap_q} + {1'b0, ACS_CAP_MARGIN} <= {1'b0, res_q});
   // 384fs and 192fs need the enable from the audio control word
   assign rate_sel_ok_o = !((rate_q == ACS_RATE_384 || rate_q == ACS_RATE_192)
      && !mid_multiple_rate_enable_i);

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   logic [15:0] rword;
   always_comb begin
      case (idx)
         ACS_IDX_NUM_LO: rword = num_lo;
         ACS_IDX_NUM_HI: rword = num_hi;
         ACS_IDX_DEN_LO: rword = den_lo;
         ACS_IDX_DEN_HI: rword = den_hi;
         ACS_IDX_CAP: rword = 16'(cap_q);
         ACS_IDX_RES: rword = 16'(res_q);
         ACS_IDX_FB_LO: rword = fb_lo;
         ACS_IDX_FB_HI: rword = fb_hi;
         ACS_IDX_REF_LO: rword = ref_lo;
         ACS_IDX_REF_HI: rword = ref_hi;
         ACS_IDX_RATE: rword = 16'(rate_q);
         ACS_IDX_UPD: rword = 16'(upd_q);
         default: rword = 16'h0000;
      endcase
   end
   // the value the word holds when the request is seen comes back
   assign rdat_next = (st_reg == ACS_IDLE && req && !wb_we_i) ? {16'h0000, rword} : rdat_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_ack_one;
      @(posedge clk_i) disable iff (rst_i)
         (st_reg == ACS_IDLE && req && hit) |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle");

   property p_upd_take;
      @(posedge clk_i) disable iff (rst_i)
         (upd_rise && {num_hi, num_lo} != 32'h0 && !rate_def_stb_i)
         |=> audio_ratio_numerator_o == $past({num_hi, num_lo});
   endproperty
   a_upd_take: assert property (p_upd_take) else $error("numerator not taken");

   property p_zero_keep;
      @(posedge clk_i) disable iff (rst_i)
         (upd_rise && {den_hi, den_lo} == 32'h0 && !rate_def_stb_i)
         |=> $stable(audio_ratio_denominator_o);
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero denominator taken");

   property p_no_upd_hold;
      @(posedge clk_i) disable iff (rst_i)
         (!upd_rise && !rate_def_stb_i) |=> $stable(audio_ratio_numerator_o);
   endproperty
   a_no_upd_hold: assert property (p_no_upd_hold) else $error("ratio changed alone");

   property p_fb_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_fb_hi && lane == 2'h3 && !std_def_stb_i)
         |=> lock_feedback_div_o[31:16] == $past(wb_dat_i[15:0]);
   endproperty
   a_fb_write: assert property (p_fb_write) else $error("feedback high half wrong");

   property p_ref_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_ref_lo && lane == 2'h3 && !std_def_stb_i)
         |=> lock_reference_div_o[15:0] == $past(wb_dat_i[15:0]);
   endproperty
   a_ref_write: assert property (p_ref_write) else $error("reference low half wrong");

   property p_rate_reset;
      @(posedge clk_i) rst_i |=> audio_clock_out_first_rate_o == ACS_RATE_RST;
   endproperty
   a_rate_reset: assert property (p_rate_reset) else $error("rate select not reset");

   property p_def_fs;
      @(posedge clk_i) disable iff (rst_i)
         (fs_def_stb_i) |=> loop_res_o == $past(def_res_i) && loop_cap_o == $past(def_cap_i);
   endproperty
   a_def_fs: assert property (p_def_fs) else $error("loop defaults not loaded");

   sequence s_take_miss;
      (st_reg == ACS_IDLE) && req && !hit;
   endsequence

   sequence s_err_pulse;
      (wb_err_o && !wb_ack_o) ##1 !wb_err_o;
   endsequence

   // an unmapped index answers once with err and never with ack
   property p_err_one;
      @(posedge clk_i) disable iff (rst_i)
         s_take_miss |=> s_err_pulse;
   endproperty
   a_err_one: assert property (p_err_one) else $error("err not a single cycle");

   sequence s_take_read_lo;
      (st_reg == ACS_IDLE) && req && !wb_we_i && idx == ACS_IDX_NUM_LO;
   endsequence

   property p_read_lo;
      @(posedge clk_i) disable iff (rst_i)
         s_take_read_lo
         |=> wb_ack_o && wb_dat_o == {16'h0000, $past(num_lo)};
   endproperty
   a_read_lo: assert property (p_read_lo) else $error("read data not last write");

   property p_den_take;
      @(posedge clk_i) disable iff (rst_i)
         (upd_rise && {den_hi, den_lo} != 32'h0 && !rate_def_stb_i)
         |=> audio_ratio_denominator_o == $past({den_hi, den_lo});
   endproperty
   a_den_take: assert property (p_den_take) else $error("denominator not taken");

   property p_def_rate;
      @(posedge clk_i) disable iff (rst_i)
         rate_def_stb_i |=> audio_ratio_numerator_o == $past(def_num_i)
            && audio_ratio_denominator_o == $past(def_den_i);
   endproperty
   a_def_rate: assert property (p_def_rate) else $error("ratio defaults not loaded");

   property p_def_std;
      @(posedge clk_i) disable iff (rst_i)
         std_def_stb_i |=> lock_feedback_div_o == $past(def_fb_i)
            && lock_reference_div_o == $past(def_ref_i);
   endproperty
   a_def_std: assert property (p_def_std) else $error("divide defaults not loaded");

   property p_rate_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_rate && lane == 2'h3) |=> audio_clock_out_first_rate_o == $past(wb_dat_i[2:0]);
   endproperty
   a_rate_write: assert property (p_rate_write) else $error("rate select not written");
endmodule // acs_regs

// file: tb.sv
// tb: self-checking bench for the audio clock synthesis configuration bank
// assumes acs_pkg is compiled first; the bench acts as the wishbone master and the default sources
`timescale 1ns/10ps
module tb
   import acs_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, err, rsel_ok, range_ok;
   logic rate_stb = 1'b0, fs_stb = 1'b0, std_stb = 1'b0, mid_en = 1'b0;
   logic [31:0] dnum = 32'h0, dden = 32'h0, dfb = 32'h0, dref = 32'h0;
   logic [5:0] dcap = 6'h0, dres = 6'h0, cap_o, res_o;
   logic [31:0] num_o, den_o, fb_o, ref_o;
   logic [2:0] rate_o;
   int error_cnt = 0;
   int checked = 0;
   logic [31:0] rd;
   logic e;
   logic [5:0] cap_t[8] = '{6'h0a, 6'h09, 6'h0b, 6'h0c, 6'h15, 6'h16, 6'h0a, 6'h0a};
   logic [5:0] res_t[8] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h2a, 6'h2a, 6'h1f, 6'h2b};
   logic ok_t[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   always #5 clk_i = ~clk_i;

   acs_regs DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .rate_def_stb_i(rate_stb), .def_num_i(dnum), .def_den_i(dden),
      .fs_def_stb_i(fs_stb), .def_cap_i(dcap), .def_res_i(dres), .std_def_stb_i(std_stb),
      .def_fb_i(dfb), .def_ref_i(dref), .mid_multiple_rate_enable_i(mid_en),
      .audio_ratio_numerator_o(num_o), .audio_ratio_denominator_o(den_o),
      .loop_cap_o(cap_o), .loop_res_o(res_o), .lock_feedback_div_o(fb_o),
      .lock_reference_div_o(ref_o), .audio_clock_out_first_rate_o(rate_o),
      .loop_range_ok_o(range_ok), .rate_sel_ok_o(rsel_ok)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one classic cycle; held until ack or err is sampled high at a rising edge
   task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     output logic [31:0] r, output logic got_err);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      wdat <= {16'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      if (n >= 50)
         chk(32'h1, 32'h0);
      r = rdat;
      got_err = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // write values respect the reserved-zero upper bits of the narrow words
   function automatic logic [15:0] pat(input logic [7:0] idx);
      logic [15:0] v;
      v = {8'h5a ^ idx, idx ^ 8'hc3};
      if (idx == ACS_IDX_CAP || idx == ACS_IDX_RES)
         return {10'h0, v[5:0]};
      if (idx == ACS_IDX_RATE)
         return {13'h0, v[2:0]};
      if (idx == ACS_IDX_RSV_A || idx == ACS_IDX_RSV_B)
         return 16'h0;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ACS_IDX_RATE, 16'h0, rd, e);
      chk(rd, 32'h0);
      chk({29'h0, rate_o}, 32'h0);
      // every word from 33h to 3Fh written, then read back
      for (int i = 8'h33; i <= 8'h3f; i++) begin
         wb(1'b1, i[7:0], (i == 8'h37 || i == 8'h38) ? 16'hffff : pat(i[7:0]), rd, e);
         chk({31'h0, e}, 32'h0);
      end
      for (int i = 8'h33; i <= 8'h3f; i++) begin
         wb(1'b0, i[7:0], 16'h0, rd, e);
         chk(rd, {16'h0, pat(i[7:0])});
      end
      settle(1);
      chk(num_o, 32'h0);
      chk(fb_o, {pat(ACS_IDX_FB_HI), pat(ACS_IDX_FB_LO)});
      chk(ref_o, {pat(ACS_IDX_REF_HI), pat(ACS_IDX_REF_LO)});
      chk({26'h0, cap_o}, {16'h0, pat(ACS_IDX_CAP)});
      chk({26'h0, res_o}, {16'h0, pat(ACS_IDX_RES)});
      // unmapped words answer with err and read zero
      wb(1'b1, 8'h20, 16'h1234, rd, e);
      chk({31'h0, e}, 32'h1);
      wb(1'b0, 8'h40, 16'h0, rd, e);
      chk({31'h0, e}, 32'h1);
      chk(rd, 32'h0);
      // rising update bit puts the ratio in use
      wb(1'b1, ACS_IDX_UPD, 16'h1, rd, e);
      settle(3);
      chk(num_o, {pat(ACS_IDX_NUM_HI), pat(ACS_IDX_NUM_LO)});
      chk(den_o, {pat(ACS_IDX_DEN_HI), pat(ACS_IDX_DEN_LO)});
      // zero numerator is kept, non-zero denominator taken
      wb(1'b1, ACS_IDX_NUM_LO, 16'h0, rd, e);
      wb(1'b1, ACS_IDX_NUM_HI, 16'h0, rd, e);
      wb(1'b1, ACS_IDX_DEN_LO, 16'h0007, rd, e);
      wb(1'b1, ACS_IDX_DEN_HI, 16'h8000, rd, e);
      settle(2);
      chk(den_o, {pat(ACS_IDX_DEN_HI), pat(ACS_IDX_DEN_LO)});
      wb(1'b1, ACS_IDX_UPD, 16'h0, rd, e);
      wb(1'b1, ACS_IDX_UPD, 16'h1, rd, e);
      settle(3);
      chk(num_o, {pat(ACS_IDX_NUM_HI), pat(ACS_IDX_NUM_LO)});
      chk(den_o, 32'h8000_0007);
      // default loads from the rate, fs and video standard selections
      @(posedge clk_i);
      dnum <= 32'h0001_2345;
      dden <= 32'h0006_789a;
      dcap <= 6'h0c;
      dres <= 6'h22;
      dfb <= 32'h00ab_cdef;
      dref <= 32'h0012_3456;
      rate_stb <= 1'b1;
      fs_stb <= 1'b1;
      std_stb <= 1'b1;
      @(posedge clk_i);
      rate_stb <= 1'b0;
      fs_stb <= 1'b0;
      std_stb <= 1'b0;
      settle(2);
      chk(num_o, 32'h0001_2345);
      chk(den_o, 32'h0006_789a);
      chk({26'h0, cap_o}, 32'h0c);
      chk({26'h0, res_o}, 32'h22);
      chk(fb_o, 32'h00ab_cdef);
      chk(ref_o, 32'h0012_3456);
      wb(1'b0, ACS_IDX_NUM_HI, 16'h0, rd, e);
      chk(rd, 32'h0001);
      wb(1'b0, ACS_IDX_REF_LO, 16'h0, rd, e);
      chk(rd, 32'h3456);
      // loop bandwidth range status at its boundaries
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, ACS_IDX_RES, {10'h0, res_t[i]}, rd, e);
         wb(1'b1, ACS_IDX_CAP, {10'h0, cap_t[i]}, rd, e);
         settle(1);
         chk({31'h0, range_ok}, {31'h0, ok_t[i]});
      end
      // every rate code, with and without the mid multiple enable
      for (int c = 0; c < 8; c++) begin
         for (int m = 0; m < 2; m++) begin
            @(posedge clk_i);
            mid_en <= m[0];
            wb(1'b1, ACS_IDX_RATE, {13'h0, c[2:0]}, rd, e);
            settle(1);
            chk({29'h0, rate_o}, {29'h0, c[2:0]});
            chk({31'h0, rsel_ok}, {31'h0, !((c == 1 || c == 3) && m == 0)});
         end
      end
      // a second reset clears the rate word
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(1);
      chk({29'h0, rate_o}, 32'h0);
      report_and_stop();
   end
endmodule // tb
